/* sdm_pkg.sv */
// Constants, register map and decode tables for the step and direction control block
// Notes on behaviour
// - Step mode: each step rising edge moves one microstep
// - Dual mode: step rising edge is clockwise microstep
// - Step mode: direction level picks rotation direction
// - Dual mode: direction rising edge is counter-clockwise microstep
// - Enable high runs, low disables; open means enabled
// - Ready output active only while operating normally
// - Mode switch on selects dual-pulse, off step-direction
// - Four current switches select sixteen peak currents
// - Four resolution switches select sixteen microstep counts
package sdm_pkg;
   // ****************************************
   // Bus widths
   // ****************************************
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int OFS_W = 8;
   localparam int FAULT_W = 5;
   localparam int IRQ_W = 3;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_POSITION = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_IDLE_TIME = 8'h14;
   localparam logic [7:0] OFS_SETTINGS = 8'h18;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_FAULT_CLR_BIT = 1;
   localparam int ST_READY_BIT = 0;
   localparam int ST_DUAL_BIT = 1;
   localparam int ST_CW_BIT = 2;
   localparam int ST_IDLE_BIT = 3;
   localparam int ST_FAULT_LSB = 8;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_IDLE_BIT = 1;
   localparam int IRQ_DROP_BIT = 2;
   localparam int SET_USTEP_LSB = 16;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic RST_ENABLE = 1'b1;
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int IDLE_TIME_MS = 500;
   localparam logic [31:0] IDLE_CYCLES = 32'(IDLE_TIME_MS * (CLK_HZ / 1000));
   // ****************************************
   // Decode tables
   // ****************************************
   // Peak run current in units of 10 mA, switch code on = 1
   function automatic logic [9:0] run_current_ca(input logic [3:0] code);
      logic [9:0] v;
      v = 10'd0;
      unique case (code)
         4'h0: v = 10'd45;
         4'h1: v = 10'd63;
         4'h2: v = 10'd141;
         4'h3: v = 10'd188;
         4'h4: v = 10'd233;
         4'h5: v = 10'd285;
         4'h6: v = 10'd323;
         4'h7: v = 10'd375;
         4'h8: v = 10'd426;
         4'h9: v = 10'd465;
         4'ha: v = 10'd518;
         4'hb: v = 10'd555;
         4'hc: v = 10'd615;
         4'hd: v = 10'd660;
         4'he: v = 10'd720;
         4'hf: v = 10'd780;
      endcase
      return v;
   endfunction
   // Microsteps per revolution, index counts an off switch as one
   function automatic logic [13:0] usteps_per_rev(input logic [3:0] idx);
      logic [13:0] v;
      v = 14'd0;
      unique case (idx)
         4'h0: v = 14'd400;
         4'h1: v = 14'd500;
         4'h2: v = 14'd600;
         4'h3: v = 14'd800;
         4'h4: v = 14'd1000;
         4'h5: v = 14'd1200;
         4'h6: v = 14'd1600;
         4'h7: v = 14'd2000;
         4'h8: v = 14'd2400;
         4'h9: v = 14'd3200;
         4'ha: v = 14'd4000;
         4'hb: v = 14'd5000;
         4'hc: v = 14'd6000;
         4'hd: v = 14'd6400;
         4'he: v = 14'd8000;
         4'hf: v = 14'd10000;
      endcase
      return v;
   endfunction
endpackage

/* sdm_edge.sv */
// Rising edge detector for the step and direction inputs
`timescale 1ns/10ps
module sdm_edge (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [1:0] i_level,
   output logic [1:0] o_level,
   output logic [1:0] o_rise
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [1:0] prev;  // Input seen last cycle
      logic [1:0] rise;  // One-cycle rise pulse
   } sdm_edge_s;
   sdm_edge_s st_reg;
   sdm_edge_s st_next;

   // Edge detect; inputs are already synchronous so no extra stage
   always_comb begin
      st_next = st_reg;
      st_next.prev = i_level;
      st_next.rise = i_level & ~st_reg.prev;
   end

   // Register the state
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_level = st_reg.prev;
   assign o_rise = st_reg.rise;
endmodule

/* sdm_ahb_slave.sv */
// AHB-Lite slave front end: address capture and one wait state
`timescale 1ns/10ps
module sdm_ahb_slave (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [sdm_pkg::ADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_access,
   output logic o_write,
   output logic [sdm_pkg::OFS_W-1:0] o_addr
);
   import sdm_pkg::*;
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic pend;               // Data phase in progress
      logic wr;                 // Pending access is a write
      logic [OFS_W-1:0] addr;   // Captured byte offset
      logic rdy;                // Registered hreadyout
   } sdm_ahb_s;
   sdm_ahb_s st_reg;
   sdm_ahb_s st_next;
   logic take;

   // Capture a NONSEQ or SEQ address phase; stall one cycle so read data
   // can come from a flop rather than a long decode path
   always_comb begin
      st_next = st_reg;
      take = i_hsel && i_htrans[1] && i_hready;
      if (st_reg.pend) begin
         // Wait state this cycle; access completes in the next
         st_next.pend = 1'b0;
         st_next.rdy = 1'b1;
      end else if (take) begin
         st_next.pend = 1'b1;
         st_next.wr = i_hwrite;
         st_next.addr = i_haddr[OFS_W-1:0];
         st_next.rdy = 1'b0;
      end
   end

   // Register the state
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg <= '{pend: 1'b0, wr: 1'b0, addr: '0, rdy: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_hreadyout = st_reg.rdy;
   assign o_access = st_reg.pend;
   assign o_write = st_reg.wr;
   assign o_addr = st_reg.addr;
endmodule

/* sdm_core.sv */
// Step and direction control core with register file and interrupt
`timescale 1ns/10ps
module sdm_core #(
   parameter logic [31:0] P_IDLE_CYCLES = sdm_pkg::IDLE_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // Isolated control inputs
   input wire logic i_step_pulse_in,
   input wire logic i_dir_in,
   input wire logic i_drive_enable_in,
   input wire logic i_pulse_mode_select,
   input wire logic [3:0] i_run_current_code,
   input wire logic [3:0] i_resolution_code,
   input wire logic [sdm_pkg::FAULT_W-1:0] i_fault,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [sdm_pkg::ADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [sdm_pkg::DATA_W-1:0] i_hwdata,
   output logic [sdm_pkg::DATA_W-1:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Drive outputs
   output logic o_step,
   output logic o_step_cw,
   output logic [31:0] o_position,
   output logic [9:0] o_current_ca,
   output logic [13:0] o_usteps_rev,
   output logic o_ready,
   output logic o_irq
);
   import sdm_pkg::*;
   // ****************************************
   // Overview
   // ****************************************
   // Pins to o_step take two clocks in both modes:
   // one for the edge detector, one for the decision.
   // Every output but o_hresp is a flop of a state register,
   // at the price of one cycle on ready and current.
   // A step refused while halted is dropped, never
   // queued: a replay would move the shaft later.
   // Faults latch until software clears them, so a
   // glitch on a cause line cannot restart the motor.

   // ****************************************
   // State
   // ****************************************
   // All state lives in one struct: one comb pass fills
   // the copy, one flop process registers it, so no
   // field can slip out of the reset
   typedef struct packed {
      logic en_sw;              // Software enable
      logic [FAULT_W-1:0] flt;  // Latched fault causes
      logic [IRQ_W-1:0] irq_st; // Sticky event flags
      logic [IRQ_W-1:0] irq_mk; // Event mask
      logic [31:0] idle_time;   // Idle interval in cycles
      logic [31:0] idle_cnt;    // Cycles since last step
      logic idle;               // Idle current active
      logic [31:0] pos;         // Signed microstep position
      logic step;               // Microstep pulse out
      logic cw;                 // Direction of last move
      logic dual;               // Dual-pulse mode
      logic ready;              // Ready output
      logic irq;                // Interrupt output
      logic [9:0] cur;          // Commanded current
      logic [13:0] ustep;       // Microsteps per revolution
      logic [31:0] rdata;       // Read data
   } sdm_core_s;
   sdm_core_s st_reg;
   sdm_core_s st_next;

   // ****************************************
   // Submodules
   // ****************************************
   // Wires from the two helpers
   logic [1:0] in_level;
   logic [1:0] in_rise;
   logic acc;
   logic acc_wr;
   logic [OFS_W-1:0] acc_addr;

   // Edges of step (bit 0) and direction (bit 1)
   // Levels come back one cycle late to line up
   // with the rise pulses
   sdm_edge u_edge (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_level({i_dir_in, i_step_pulse_in}),
      .o_level(in_level),
      .o_rise(in_rise)
   );

   // Bus front end
   // Always one wait state; read data leaves from a
   // flop, which keeps the decode off the bus path
   sdm_ahb_slave u_ahb (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hready(i_hready),
      .o_hreadyout(o_hreadyout),
      .o_access(acc),
      .o_write(acc_wr),
      .o_addr(acc_addr)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   // Per-cycle helpers, each set in the pass before it is read
   logic operating;
   logic step_req;
   logic step_cw;
   logic moved;
   logic wr;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] w1c;
   logic [FAULT_W-1:0] flt_now;
   logic [9:0] run_cur;

   // One pass builds the whole next state: stepping
   // first, then faults and the idle timer, then the
   // register writes, which win on shared fields.
   // Sticky flags merge new events after the clear,
   // so an event is never lost to a write.
   // Reads use registered state only.
   always_comb begin
      st_next = st_reg;
      ev = '0;
      w1c = '0;
      wr = acc && acc_wr;
      flt_now = st_reg.flt | i_fault;
      st_next.dual = i_pulse_mode_select;
      operating = i_drive_enable_in && st_reg.en_sw && (st_reg.flt == '0);
      // Work out requested move for this cycle
      // The direction latch only moves with an accepted
      // step, so o_step_cw never shows a refused pulse.
      // Dual mode needs no direction setup time.
      step_req = 1'b0;
      step_cw = st_reg.cw;
      if (st_reg.dual) begin
         if (in_rise[0] && !in_rise[1]) begin
            step_req = 1'b1;
            step_cw = 1'b1;
         end else if (in_rise[1] && !in_rise[0]) begin
            step_req = 1'b1;
            step_cw = 1'b0;
         end
         // Both edges together cancel out: net motion zero
         // A controller firing both lines at once is out of
         // spec; cancelling keeps the position count honest
      end else begin
         if (in_rise[0]) begin
            step_req = 1'b1;
            step_cw = in_level[1];
         end
      end
      // Refused steps still raise a flag, so software sees
      // a controller that kept pulsing into a halted drive
      // faults halt stepping
      moved = step_req && operating;
      st_next.step = moved;
      if (moved) begin
         st_next.cw = step_cw;
         st_next.pos = step_cw ? st_reg.pos + 32'h1 : st_reg.pos - 32'h1;
      end
      if (step_req && !operating) begin
         ev[IRQ_DROP_BIT] = 1'b1;
      end
      if ((i_fault & ~st_reg.flt) != '0) begin
         ev[IRQ_FAULT_BIT] = 1'b1;
      end
      st_next.flt = flt_now;
      // The counter stops at the interval rather than
      // wrapping, so a long pause never restores full
      // current by itself. Rewriting the interval does
      // not leave idle; only an accepted step does.
      // idle timer
      if (moved) begin
         st_next.idle_cnt = '0;
         st_next.idle = 1'b0;
      end else if (st_reg.idle_cnt < st_reg.idle_time) begin
         st_next.idle_cnt = st_reg.idle_cnt + 32'h1;
      end else if (!st_reg.idle) begin
         st_next.idle = 1'b1;
         ev[IRQ_IDLE_BIT] = 1'b1;
      end
      // Decoding the switches every cycle lets a changed
      // code take effect without a restart
      // run current decode
      run_cur = run_current_ca(i_run_current_code);
      // Halving is a shift: cheap, and close enough for
      // coil heating; a finer ratio needs a multiplier.
      // It follows the switch code live.
      // idle level is half the run current
      st_next.cur = st_next.idle ? {1'b0, run_cur[9:1]} : run_cur;
      st_next.ustep = usteps_per_rev(~i_resolution_code);
      // Register writes
      // Only the low address byte is decoded, so the map
      // repeats every 256 bytes; read-only offsets ignore
      // writes
      if (wr) begin
         unique case (acc_addr)
            OFS_CTRL: begin
               st_next.en_sw = i_hwdata[CTRL_ENABLE_BIT];
               // Fault clear only drops causes that have gone away
               if (i_hwdata[CTRL_FAULT_CLR_BIT]) begin
                  st_next.flt = i_fault;
               end
            end
            OFS_IRQ_STATUS: w1c = i_hwdata[IRQ_W-1:0];
            OFS_IRQ_MASK: st_next.irq_mk = i_hwdata[IRQ_W-1:0];
            OFS_IDLE_TIME: st_next.idle_time = i_hwdata;
            default: ;
         endcase
      end
      // Sticky flags: a new event beats a write-one clear
      st_next.irq_st = (st_reg.irq_st & ~w1c) | ev;
      // Interrupt follows the next state, rising with the flag
      st_next.irq = |(st_next.irq_st & st_next.irq_mk);
      // Ready uses the next enable and fault state, so it
      // drops in the same cycle the fault latches
      // ready while operating
      st_next.ready = i_drive_enable_in && st_next.en_sw && (st_next.flt == '0);
      // Read data captured in the first data-phase cycle
      // and held until the next read; writes leave it
      // alone so a late sample still sees the old word
      st_next.rdata = '0;
      if (acc && !acc_wr) begin
         unique case (acc_addr)
            OFS_CTRL: st_next.rdata[CTRL_ENABLE_BIT] = st_reg.en_sw;
            OFS_STATUS: begin
               st_next.rdata[ST_READY_BIT] = st_reg.ready;
               st_next.rdata[ST_DUAL_BIT] = st_reg.dual;
               st_next.rdata[ST_CW_BIT] = st_reg.cw;
               st_next.rdata[ST_IDLE_BIT] = st_reg.idle;
               st_next.rdata[ST_FAULT_LSB +: FAULT_W] = st_reg.flt;
            end
            OFS_POSITION: st_next.rdata = st_reg.pos;
            OFS_IRQ_STATUS: st_next.rdata[IRQ_W-1:0] = st_reg.irq_st;
            OFS_IRQ_MASK: st_next.rdata[IRQ_W-1:0] = st_reg.irq_mk;
            OFS_IDLE_TIME: st_next.rdata = st_reg.idle_time;
            OFS_SETTINGS: begin
               st_next.rdata[9:0] = st_reg.cur;
               st_next.rdata[SET_USTEP_LSB +: 14] = st_reg.ustep;
            end
            // Unmapped offsets read zero
            default: ;
         endcase
      end else begin
         st_next.rdata = st_reg.rdata;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Reset: drive not ready until the first clocked evaluation
   // Software enable starts set so a board with no bus
   // master runs from the pins alone; the mask starts
   // clear so nothing interrupts before software sets
   // it up. Position starts at zero, direction cw.
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg <= '{en_sw: RST_ENABLE, flt: '0, irq_st: '0, irq_mk: RST_IRQ_MASK,
                     idle_time: P_IDLE_CYCLES, idle_cnt: '0, idle: 1'b0, pos: '0,
                     step: 1'b0, cw: 1'b1, dual: 1'b0, ready: 1'b0, irq: 1'b0,
                     cur: '0, ustep: '0, rdata: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // All but o_hresp straight from the state register, no logic in between
   assign o_hrdata = st_reg.rdata;
   // No error response exists: every offset answers
   assign o_hresp = 1'b0;
   assign o_step = st_reg.step;
   assign o_step_cw = st_reg.cw;
   assign o_position = st_reg.pos;
   assign o_current_ca = st_reg.cur;
   assign o_usteps_rev = st_reg.ustep;
   assign o_ready = st_reg.ready;
   assign o_irq = st_reg.irq;
endmodule

/* sdm_core_assertions.sv */
// Port level checks for the step and direction control core
`timescale 1ns/10ps
module sdm_core_assertions #(
   parameter logic [31:0] P_IDLE_CYCLES = 32'd100
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_step_pulse_in,
   input wire logic i_dir_in,
   input wire logic i_drive_enable_in,
   input wire logic i_pulse_mode_select,
   input wire logic [4:0] i_fault,
   input wire logic o_step,
   input wire logic o_step_cw,
   input wire logic [31:0] o_position,
   input wire logic [9:0] o_current_ca,
   input wire logic o_ready
);
   // ********
   // Helpers
   // ********
   // Operating as the core sees it in the cycle that decides a step:
   // ready in the same cycle carries the same software and fault state
   logic op_ok;
   assign op_ok = o_ready && i_drive_enable_in;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // ********
   // Properties
   // ********
   a_step_move: assert property (!i_pulse_mode_select && $rose(i_step_pulse_in) ##1 op_ok
      |-> ##1 o_step) else $error("step rise gave no microstep");
   a_dir_level: assert property (!i_pulse_mode_select && $rose(i_step_pulse_in) ##1 op_ok
      |-> ##1 (o_step_cw == $past(i_dir_in, 2))) else $error("direction level not followed");
   a_dual_cw: assert property (i_pulse_mode_select && $rose(i_step_pulse_in)
      && !$rose(i_dir_in) ##1 op_ok
      |-> ##1 (o_step && o_step_cw)) else $error("cw pulse not stepped");
   a_dual_ccw: assert property (i_pulse_mode_select && $rose(i_dir_in)
      && !$rose(i_step_pulse_in) ##1 op_ok
      |-> ##1 (o_step && !o_step_cw)) else $error("ccw pulse lost");
   a_pos_count: assert property (o_step
      |-> o_position == $past(o_position) + (o_step_cw ? 32'h1 : 32'hffff_ffff))
      else $error("position not moved by one");
   a_enable_drop: assert property ($fell(i_drive_enable_in) |-> ##[1:3] !o_ready)
      else $error("ready stayed up while disabled");
   a_fault_drop: assert property ((i_fault != 5'h00) |-> ##[1:3] !o_ready)
      else $error("ready stayed up on fault");
   // Three cycles give the fault latch time to settle before stepping must stop
   a_halt_steps: assert property ((!i_drive_enable_in || i_fault != 5'h00) [*3] |-> !o_step)
      else $error("step issued while halted");
   a_idle_restore: assert property (o_step |-> o_current_ca >= $past(o_current_ca))
      else $error("step lowered the current");
   // Main scenarios reached
   cover property (o_step && o_step_cw);
   cover property (o_step && !o_step_cw);
   cover property ($fell(o_ready));
endmodule
bind sdm_core sdm_core_assertions #(.P_IDLE_CYCLES(P_IDLE_CYCLES)) u_chk (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_step_pulse_in(i_step_pulse_in),
   .i_dir_in(i_dir_in), .i_drive_enable_in(i_drive_enable_in),
   .i_pulse_mode_select(i_pulse_mode_select), .i_fault(i_fault), .o_step(o_step),
   .o_step_cw(o_step_cw), .o_position(o_position), .o_current_ca(o_current_ca),
   .o_ready(o_ready));

/* sdm_ctl_model.sv */
// Behavioural motion controller issuing step and direction pulses
`timescale 1ns/10ps
module sdm_ctl_model #(
   parameter int P_HI_CYC = 125,
   parameter int P_LO_CYC = 130,
   parameter int P_SETUP_CYC = 510
) (
   input wire logic i_ref_clk,
   output logic o_step_pulse,
   output logic o_dir
);
   // Lines rest low with clockwise level on direction
   initial begin
      o_step_pulse = 1'b0;
      o_dir = 1'b1;
   end
   // Send n microsteps; dual picks the clockwise and counter-clockwise wiring
   task automatic send(input logic dual, input logic cw, input int n);
      // new level settles before the first reversed pulse
      if (dual || (o_dir !== cw)) begin
         @(posedge i_ref_clk);
         o_dir <= dual ? 1'b0 : cw;
         repeat (P_SETUP_CYC) @(posedge i_ref_clk);
      end
      for (int i = 0; i < n; i++) begin
         // width above 1.2 us and period at least 2.5 us
         @(posedge i_ref_clk);
         if (dual && !cw) begin
            o_dir <= 1'b1;
         end else begin
            o_step_pulse <= 1'b1;
         end
         repeat (P_HI_CYC) @(posedge i_ref_clk);
         o_step_pulse <= 1'b0;
         o_dir <= dual ? 1'b0 : o_dir;
         repeat (P_LO_CYC - 1) @(posedge i_ref_clk);
      end
   endtask
endmodule

/* sdm_core_tb_top.sv */
// Self-checking testbench for the step and direction control core
`timescale 1ns/10ps
module sdm_core_tb_top;
   import sdm_pkg::*;
   logic i_ref_clk, i_rstn, i_step_pulse_in, i_dir_in, i_drive_enable_in, i_pulse_mode_select;
   logic [3:0] i_run_current_code, i_resolution_code;
   logic [4:0] i_fault;
   logic i_hsel, i_htrans1, i_hwrite, o_hreadyout, o_hresp, o_step, o_step_cw, o_ready, o_irq;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, o_position, rd;
   logic [9:0] o_current_ca;
   logic [13:0] o_usteps_rev;
   int fails = 0;
   int checks_done = 0;
   // Expected peak current in 10 mA units and microsteps per revolution
   int cur_t[16] = '{45, 63, 141, 188, 233, 285, 323, 375, 426, 465, 518, 555, 615, 660, 720,
      780};
   int ust_t[16] = '{400, 500, 600, 800, 1000, 1200, 1600, 2000, 2400, 3200, 4000, 5000, 6000,
      6400, 8000, 10000};
   // Far side controller and the block itself
   sdm_ctl_model u_ctl (.i_ref_clk(i_ref_clk), .o_step_pulse(i_step_pulse_in), .o_dir(i_dir_in));
   // Idle interval kept long so that it only matters once rewritten
   sdm_core #(.P_IDLE_CYCLES(32'd100000)) DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_step_pulse_in(i_step_pulse_in), .i_dir_in(i_dir_in),
      .i_drive_enable_in(i_drive_enable_in), .i_pulse_mode_select(i_pulse_mode_select),
      .i_run_current_code(i_run_current_code), .i_resolution_code(i_resolution_code),
      .i_fault(i_fault), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans({i_htrans1, 1'b0}),
      .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hready(o_hreadyout), .i_hwdata(i_hwdata),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_step(o_step),
      .o_step_cw(o_step_cw), .o_position(o_position), .o_current_ca(o_current_ca),
      .o_usteps_rev(o_usteps_rev), .o_ready(o_ready), .o_irq(o_irq));
   // Free running 100 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   // Count and report one comparison
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single word transfer; waits on the bus ready, read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_hsel <= 1'b1;
      i_htrans1 <= 1'b1;
      i_haddr <= {24'h000000, a};
      i_hwrite <= w;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans1 <= 1'b0;
      i_hwdata <= d;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      rd = o_hrdata;
   endtask
   // Verdict and end of run
   task automatic stop_test();
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 6600 cycles
   initial begin
      repeat (30000) @(posedge i_ref_clk);
      fails++;
      stop_test();
   end
   // Main sequence
   initial begin
      {i_rstn, i_pulse_mode_select, i_fault, i_hsel, i_htrans1, i_hwrite} = '0;
      {i_haddr, i_hwdata} = '0;
      i_drive_enable_in = 1'b1;
      {i_run_current_code, i_resolution_code} = 8'h00;
      repeat (5) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      @(posedge i_ref_clk);
      for (int k = 0; k < 16; k++) begin
         i_run_current_code <= 4'(k);
         i_resolution_code <= 4'(k);
         repeat (3) @(posedge i_ref_clk);
         cmp(32'(o_current_ca), 32'(cur_t[k]));
         cmp(32'(o_usteps_rev), 32'(ust_t[15 - k]));
      end
      cmp(32'(o_ready), 32'h1);
      u_ctl.send(1'b0, 1'b1, 3);
      cmp(o_position, 32'd3);
      u_ctl.send(1'b0, 1'b0, 2);
      cmp(o_position, 32'd1);
      cmp(32'(o_step_cw), 32'h0);
      i_pulse_mode_select <= 1'b1;
      u_ctl.send(1'b1, 1'b1, 2);
      cmp(o_position, 32'd3);
      u_ctl.send(1'b1, 1'b0, 3);
      cmp(o_position, 32'd0);
      ahb(1'b0, OFS_STATUS, 32'h0);
      cmp(rd & 32'h3, 32'h3);
      // Disabled drive drops the step and flags it
      i_drive_enable_in <= 1'b0;
      u_ctl.send(1'b1, 1'b1, 1);
      cmp(o_position, 32'd0);
      cmp(32'(o_ready), 32'h0);
      ahb(1'b0, OFS_IRQ_STATUS, 32'h0);
      cmp(rd, 32'h4);
      ahb(1'b1, OFS_IRQ_MASK, 32'h4);
      repeat (2) @(posedge i_ref_clk);
      cmp(32'(o_irq), 32'h1);
      ahb(1'b1, OFS_IRQ_STATUS, 32'h4);
      repeat (2) @(posedge i_ref_clk);
      cmp(32'(o_irq), 32'h0);
      i_drive_enable_in <= 1'b1;
      // Latched fault halts stepping until cleared
      i_fault <= 5'h04;
      repeat (4) @(posedge i_ref_clk);
      cmp(32'(o_ready), 32'h0);
      u_ctl.send(1'b1, 1'b1, 1);
      cmp(o_position, 32'd0);
      i_fault <= 5'h00;
      ahb(1'b1, OFS_CTRL, 32'h3);
      repeat (3) @(posedge i_ref_clk);
      cmp(32'(o_ready), 32'h1);
      ahb(1'b0, OFS_IRQ_STATUS, 32'h0);
      cmp(rd, 32'h5);
      // Unmapped place ignores writes and reads zero
      ahb(1'b1, 8'h1c, 32'hffff_ffff);
      ahb(1'b0, 8'h1c, 32'h0);
      cmp(rd, 32'h0);
      // Short idle interval halves the current, next step restores it
      ahb(1'b1, OFS_IDLE_TIME, 32'd40);
      repeat (80) @(posedge i_ref_clk);
      cmp(32'(o_current_ca), 32'd390);
      ahb(1'b1, OFS_IDLE_TIME, 32'd5000);
      u_ctl.send(1'b1, 1'b1, 1);
      cmp(32'(o_current_ca), 32'd780);
      cmp(o_position, 32'd1);
      // Registers mirror the position and the decoded switches
      ahb(1'b0, OFS_POSITION, 32'h0);
      cmp(rd, 32'd1);
      ahb(1'b0, OFS_SETTINGS, 32'h0);
      cmp(rd, (32'(ust_t[0]) << SET_USTEP_LSB) | 32'(cur_t[15]));
      cmp(32'(o_hresp), 32'h0);
      // Software disable drops ready, re-enable restores it
      ahb(1'b1, OFS_CTRL, 32'h0);
      repeat (2) @(posedge i_ref_clk);
      cmp(32'(o_ready), 32'h0);
      ahb(1'b1, OFS_CTRL, 32'h1);
      repeat (2) @(posedge i_ref_clk);
      cmp(32'(o_ready), 32'h1);
      stop_test();
   end
endmodule
